// ### pkg/evrt_pkg.sv
package evrt_pkg;

  localparam int EVRT_NUM_SRC = 26;
  localparam int EVRT_NUM_DST = 10;
  localparam int EVRT_CODE_W  = 4;
  localparam int EVRT_ADDR_W  = 22;

  typedef logic [EVRT_CODE_W-1:0] evrt_code_t;

  // Destination codes held in the low nibble of each select register
  localparam evrt_code_t EVRT_CODE_OFF  = 4'h0;
  localparam evrt_code_t EVRT_CODE_ADC  = 4'h1;
  localparam evrt_code_t EVRT_CODE_CH0  = 4'h2;
  localparam evrt_code_t EVRT_CODE_CH1  = 4'h3;
  localparam evrt_code_t EVRT_CODE_CNT  = 4'h4;
  localparam evrt_code_t EVRT_CODE_CAP0 = 4'h5;
  localparam evrt_code_t EVRT_CODE_CAP1 = 4'h6;
  localparam evrt_code_t EVRT_CODE_DAC  = 4'h7;
  localparam evrt_code_t EVRT_CODE_CH2  = 4'h8;
  localparam evrt_code_t EVRT_CODE_CH3  = 4'h9;
  localparam evrt_code_t EVRT_CODE_PWM  = 4'hA;

  // Bit position of each destination in the hit vector: code minus one
  localparam int EVRT_DST_ADC  = 0;
  localparam int EVRT_DST_CH0  = 1;
  localparam int EVRT_DST_CH1  = 2;
  localparam int EVRT_DST_CNT  = 3;
  localparam int EVRT_DST_CAP0 = 4;
  localparam int EVRT_DST_CAP1 = 5;
  localparam int EVRT_DST_DAC  = 6;
  localparam int EVRT_DST_CH2  = 7;
  localparam int EVRT_DST_CH3  = 8;
  localparam int EVRT_DST_PWM  = 9;

  // Register indices; byte address is four times the index
  localparam logic [19:0] EVRT_SEL_IDX_FIRST = 20'hF0780;
  localparam logic [19:0] EVRT_SEL_IDX_LAST  = 20'hF0799;
  localparam logic [19:0] EVRT_STAT_IDX      = 20'hF07A0;

  localparam logic [7:0]              EVRT_SEL_RST  = 8'h00;
  localparam logic [EVRT_NUM_DST-1:0] EVRT_STAT_RST = 10'h000;

  // Worst-case detection latencies allowed per destination, in cycles
  localparam int EVRT_CH_MAX_CYC  = 4;
  localparam int EVRT_CAP_MAX_CYC = 3;
  localparam int EVRT_DAC_MAX_CYC = 2;
  localparam int EVRT_PWM_MAX_CYC = 2;

endpackage

// ### pkg/evrt_route_if.sv
`timescale 1ns/1ps
interface evrt_route_if;
  import evrt_pkg::*;

  evrt_code_t                sel [EVRT_NUM_SRC];
  logic [EVRT_NUM_SRC-1:0]   src;
  logic [EVRT_NUM_DST-1:0]   hit;

  modport ctrl   (output sel, output src, input  hit);
  modport matrix (input  sel, input  src, output hit);
endinterface

// ### hw/evrt_route_matrix.sv
`timescale 1ns/1ps
module evrt_route_matrix
  import evrt_pkg::*;
(
  evrt_route_if.matrix rt     // Select codes and source pulses in, hits out
);

  // One OR tree per destination; a source reaches only the code it holds
  genvar d;
  genvar s;
  generate
    for (d = 0; d < EVRT_NUM_DST; d++)
    begin : g_dst
      logic [EVRT_NUM_SRC-1:0] match;
      for (s = 0; s < EVRT_NUM_SRC; s++)
      begin : g_src
        assign match[s] = rt.src[s] && (rt.sel[s] == evrt_code_t'(d + 1));
      end
      assign rt.hit[d] = |match;
    end
  endgenerate

endmodule

// ### hw/evrt_top.sv
`timescale 1ns/1ps
// Overview of operation
// - Event inputs separate from interrupt path.
// - Forwarding is pure hardware, no CPU.
// - One select register per source, 00-25.
// - Selects at F0780H-F0799H, reset 00H, RW.
// - Fixed source order by index.
// - Code 0000B forwards nothing.
// - Codes 1-7 to ADC..DAC in order.
// - Codes 8-A to ch2, ch3, PWM; others forbidden.
// - ADC start is direct, no delay.
// - Channel events drive timer-array channels 0-3.
// - Channel detection within 4 cycles.
// - Count timer source is direct, no delay.
// - Capture timer 0 capture and cutoff.
// - Capture timer 1 capture and cutoff.
// - Capture timers detect within 3 cycles.
// - DAC detect within 2, update next.
// - PWM detect within 2, cutoff next.
module evrt_top
  import evrt_pkg::*;
(
  input  wire logic                   sys_clk,                   // System clock, 20 MHz
  input  wire logic                   arst_n,                    // Asynchronous reset, active low
  input  wire logic                   psel,                      // APB select
  input  wire logic                   penable,                   // APB access phase
  input  wire logic                   pwrite,                    // APB write
  input  wire logic [EVRT_ADDR_W-1:0] paddr,                     // APB byte address
  input  wire logic [31:0]            pwdata,                    // APB write data
  input  wire logic [3:0]             pstrb,                     // APB byte strobes
  output logic      [31:0]            prdata,                    // APB read data
  output logic                        pready,                    // APB ready
  output logic                        pslverr,                   // APB error on unmapped address
  input  wire logic [5:0]             ext_edge_event,            // External edge detectors 0-5
  input  wire logic                   key_return_event,          // Key return
  input  wire logic                   calendar_event,            // Clock calendar
  input  wire logic                   cap_timer0_event_a,        // Capture timer 0 A
  input  wire logic                   cap_timer0_event_b,        // Capture timer 0 B
  input  wire logic                   cap_timer1_event_a,        // Capture timer 1 A
  input  wire logic                   cap_timer1_event_b,        // Capture timer 1 B
  input  wire logic                   cap_timer1_underflow_event, // Capture timer 1 underflow
  input  wire logic                   count_timer_event,         // Count timer
  input  wire logic [7:0]             unit0_ch_event,            // Timer-array unit0 channels 0-7
  input  wire logic                   comparator_event,          // Comparator
  input  wire logic [2:0]             unit1_ch_event,            // Timer-array unit1 channels 0-2
  input  wire logic                   pwm_cutoff_clear,          // PWM block releases forced cutoff
  output logic                        adc_start_trig,            // ADC conversion start
  output logic [3:0]                  unit0_ch_trig,             // Event input of unit0 channels 0-3
  output logic                        count_timer_src,           // Count timer count source
  output logic                        cap_timer0_chan_d_capture, // Capture timer 0 channel D capture
  output logic                        cap_timer0_cutoff,         // Capture timer 0 output cutoff
  output logic                        cap_timer1_chan_d_capture, // Capture timer 1 channel D capture
  output logic                        cap_timer1_cutoff,         // Capture timer 1 output cutoff
  output logic                        dac_event_detect,          // DAC event detected
  output logic                        dac_update,                // DAC real-time output update
  output logic                        pwm_cutoff_detect,         // PWM cutoff event detected
  output logic                        pwm_output_cutoff          // PWM forced cutoff state
);

  evrt_route_if rt ();

  evrt_code_t              sel_r [EVRT_NUM_SRC];
  logic [EVRT_NUM_DST-1:0] stat_r;
  logic [31:0]             prdata_r;
  logic                    pslverr_r;
  logic [3:0]              ch_trig_r;
  logic                    cap0_r;
  logic                    cap1_r;
  logic                    dac_det_r;
  logic                    dac_upd_r;
  logic                    pwm_det_r;
  logic                    pwm_cut_r;

  logic [19:0]             word_idx;
  logic                    sel_hit;
  logic                    stat_hit;
  logic [4:0]              sel_num;
  logic                    wr_acc;
  logic                    setup;
  logic [19:0]             sel_off;

  // Sources taken from their own event outputs, not the interrupt flags
  assign rt.src = {unit1_ch_event,
                   unit0_ch_event[7:5],
                   comparator_event,
                   unit0_ch_event[4:0],
                   count_timer_event,
                   cap_timer1_underflow_event,
                   cap_timer1_event_b,
                   cap_timer1_event_a,
                   cap_timer0_event_b,
                   cap_timer0_event_a,
                   calendar_event,
                   key_return_event,
                   ext_edge_event};

  genvar g;
  generate
    for (g = 0; g < EVRT_NUM_SRC; g++)
    begin : g_sel_out
      assign rt.sel[g] = sel_r[g];
    end
  endgenerate

  evrt_route_matrix u_matrix (
    .rt (rt.matrix)
  );

  // Address decode
  assign word_idx = paddr[EVRT_ADDR_W-1:2];
  assign sel_hit  = (word_idx >= EVRT_SEL_IDX_FIRST) && (word_idx <= EVRT_SEL_IDX_LAST);
  assign stat_hit = (word_idx == EVRT_STAT_IDX);
  assign sel_off  = word_idx - EVRT_SEL_IDX_FIRST;
  assign sel_num  = sel_off[4:0];
  assign setup    = psel && !penable;
  assign wr_acc   = psel && penable && pwrite;

  // Select registers; upper nibble is not stored
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < EVRT_NUM_SRC; i++)
      begin
        sel_r[i] <= EVRT_SEL_RST[EVRT_CODE_W-1:0];
      end
    end
    else if (wr_acc && sel_hit && pstrb[0])
    begin
      sel_r[sel_num] <= pwdata[EVRT_CODE_W-1:0];
    end
  end

  // Sticky per-destination activity, write one to clear; a new hit wins
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stat_r <= EVRT_STAT_RST;
    end
    else
    begin
      for (int i = 0; i < EVRT_NUM_DST; i++)
      begin
        if (rt.hit[i])
        begin
          stat_r[i] <= 1'b1;
        end
        else if (wr_acc && stat_hit && pstrb[i/8] && pwdata[i])
        begin
          stat_r[i] <= 1'b0;
        end
      end
    end
  end

  // Read data and error are prepared in the setup cycle for a zero-wait access
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
    else if (setup)
    begin
      pslverr_r <= !(sel_hit || stat_hit);
      if (pwrite)
      begin
        prdata_r <= 32'h0000_0000;
      end
      else if (sel_hit)
      begin
        prdata_r <= {28'h000_0000, sel_r[sel_num]};
      end
      else if (stat_hit)
      begin
        prdata_r <= {22'h00_0000, stat_r};
      end
      else
      begin
        prdata_r <= 32'h0000_0000;
      end
    end
  end

  assign prdata  = prdata_r;
  assign pready  = 1'b1;
  assign pslverr = pslverr_r && psel && penable;

  // Direct destinations: the hit itself is the trigger
  assign adc_start_trig  = rt.hit[EVRT_DST_ADC];
  assign count_timer_src = rt.hit[EVRT_DST_CNT];

  // Timer-array channels see the event one cycle after the source pulse
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ch_trig_r <= 4'h0;
    end
    else
    begin
      ch_trig_r <= {rt.hit[EVRT_DST_CH3], rt.hit[EVRT_DST_CH2],
                    rt.hit[EVRT_DST_CH1], rt.hit[EVRT_DST_CH0]};
    end
  end

  assign unit0_ch_trig = ch_trig_r;

  // Capture timers share the system clock here; one stage keeps them inside their limit
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cap0_r <= 1'b0;
      cap1_r <= 1'b0;
    end
    else
    begin
      cap0_r <= rt.hit[EVRT_DST_CAP0];
      cap1_r <= rt.hit[EVRT_DST_CAP1];
    end
  end

  assign cap_timer0_chan_d_capture = cap0_r;
  assign cap_timer0_cutoff         = cap0_r;
  assign cap_timer1_chan_d_capture = cap1_r;
  assign cap_timer1_cutoff         = cap1_r;

  // DAC: detect after one cycle, update pulse the cycle after
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dac_det_r <= 1'b0;
      dac_upd_r <= 1'b0;
    end
    else
    begin
      dac_det_r <= rt.hit[EVRT_DST_DAC];
      dac_upd_r <= dac_det_r;
    end
  end

  assign dac_event_detect = dac_det_r;
  assign dac_update       = dac_upd_r;

  // PWM: detect after one cycle, cutoff state holds from the next until released
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pwm_det_r <= 1'b0;
    end
    else
    begin
      pwm_det_r <= rt.hit[EVRT_DST_PWM];
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pwm_cut_r <= 1'b0;
    end
    else if (pwm_det_r)
    begin
      pwm_cut_r <= 1'b1;
    end
    else if (pwm_cutoff_clear)
    begin
      pwm_cut_r <= 1'b0;
    end
  end

  assign pwm_cutoff_detect = pwm_det_r;
  assign pwm_output_cutoff = pwm_cut_r;

endmodule

// ### testbench/evrt_top_props.sv
`timescale 1ns/1ps
module evrt_top_props
(
  input wire logic sys_clk,                   // Clock
  input wire logic arst_n,                    // Reset
  input wire logic psel,                      // Select
  input wire logic penable,                   // Access
  input wire logic pready,                    // Ready
  input wire logic pslverr,                   // Error
  input wire logic cap_timer0_chan_d_capture, // Capture 0
  input wire logic cap_timer0_cutoff,         // Cutoff 0
  input wire logic cap_timer1_chan_d_capture, // Capture 1
  input wire logic cap_timer1_cutoff,         // Cutoff 1
  input wire logic dac_event_detect,          // DAC detect
  input wire logic dac_update,                // DAC update
  input wire logic pwm_cutoff_detect,         // PWM detect
  input wire logic pwm_output_cutoff,         // PWM state
  input wire logic pwm_cutoff_clear           // PWM release
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_dac_chain;
    dac_event_detect ##1 dac_update;
  endsequence
  sequence s_pwm_chain;
    pwm_cutoff_detect ##1 pwm_output_cutoff;
  endsequence

  a_dac_chain: assert property (dac_event_detect |-> s_dac_chain) else $error("DAC update missed");
  a_dac_cause: assert property (dac_update |-> $past(dac_event_detect)) else $error("DAC update uncaused");
  a_pwm_chain: assert property (pwm_cutoff_detect |-> s_pwm_chain) else $error("PWM cutoff missed");
  a_pwm_rise: assert property ($rose(pwm_output_cutoff) |-> $past(pwm_cutoff_detect))
    else $error("PWM cutoff uncaused");
  a_pwm_hold: assert property (pwm_output_cutoff && !pwm_cutoff_clear |=> pwm_output_cutoff)
    else $error("PWM cutoff dropped");
  a_cap0_pair: assert property (cap_timer0_cutoff == cap_timer0_chan_d_capture) else $error("Cap0 split");
  a_cap1_pair: assert property (cap_timer1_cutoff == cap_timer1_chan_d_capture) else $error("Cap1 split");
  a_apb_ready: assert property (psel && penable |-> pready) else $error("No ready");
  a_err_access: assert property (pslverr |-> psel && penable) else $error("Stray error");
endmodule

bind evrt_top evrt_top_props u_props (.sys_clk, .arst_n, .psel, .penable, .pready, .pslverr,
  .cap_timer0_chan_d_capture, .cap_timer0_cutoff, .cap_timer1_chan_d_capture, .cap_timer1_cutoff,
  .dac_event_detect, .dac_update, .pwm_cutoff_detect, .pwm_output_cutoff, .pwm_cutoff_clear);

// ### testbench/evrt_periph_model.sv
`timescale 1ns/1ps
module evrt_periph_model
(
  input  wire logic        sys_clk,                    // Clock
  input  wire logic        arst_n,                     // Reset
  input  wire logic [25:0] src,                        // Pulses by source index
  input  wire logic        pwm_output_cutoff,          // Cutoff state
  output logic      [5:0]  ext_edge_event,             // Edge detectors
  output logic             key_return_event,           // Key return
  output logic             calendar_event,             // Calendar
  output logic             cap_timer0_event_a,         // Cap0 A
  output logic             cap_timer0_event_b,         // Cap0 B
  output logic             cap_timer1_event_a,         // Cap1 A
  output logic             cap_timer1_event_b,         // Cap1 B
  output logic             cap_timer1_underflow_event, // Cap1 underflow
  output logic             count_timer_event,          // Count timer
  output logic      [7:0]  unit0_ch_event,             // Unit0
  output logic             comparator_event,           // Comparator
  output logic      [2:0]  unit1_ch_event,             // Unit1
  output logic             pwm_cutoff_clear            // Cutoff release
);
  logic [1:0] hold_r;
  // Own event wires, independent of any interrupt state
  assign {unit1_ch_event, unit0_ch_event[7:5], comparator_event, unit0_ch_event[4:0], count_timer_event,
    cap_timer1_underflow_event, cap_timer1_event_b, cap_timer1_event_a, cap_timer0_event_b, cap_timer0_event_a,
    calendar_event, key_return_event, ext_edge_event} = src;
  // PWM block releases the cutoff after three cycles
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      hold_r <= 2'h0;
      pwm_cutoff_clear <= 1'b0;
    end
    else
    begin
      hold_r <= pwm_output_cutoff ? hold_r + 2'h1 : 2'h0;
      pwm_cutoff_clear <= (hold_r == 2'h2);
    end
  end
endmodule

// ### testbench/test_evrt_top.sv
`timescale 1ns/1ps
module test_evrt_top
  import evrt_pkg::*;
;
  logic sys_clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [21:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0]  pstrb = 4'hF;
  logic [25:0] src = '0;
  logic [9:0]  hit;
  logic        adc_d = 0, cnt_d = 0;
  logic [32:0] q_rd[$];
  logic [9:0]  q_hit[$];
  int          n_fail = 0, check_count = 0;
  wire [31:0] prdata;
  wire [7:0]  unit0_ch_event;
  wire [5:0]  ext_edge_event;
  wire [3:0]  unit0_ch_trig;
  wire [2:0]  unit1_ch_event;
  wire pready, pslverr, key_return_event, calendar_event, cap_timer0_event_a, cap_timer0_event_b;
  wire cap_timer1_event_a, cap_timer1_event_b, cap_timer1_underflow_event, count_timer_event;
  wire comparator_event, pwm_cutoff_clear, adc_start_trig, count_timer_src, cap_timer0_chan_d_capture;
  wire cap_timer0_cutoff, cap_timer1_chan_d_capture, cap_timer1_cutoff, dac_event_detect, dac_update;
  wire pwm_cutoff_detect, pwm_output_cutoff;

  evrt_top dut (.*);
  evrt_periph_model u_periph (.*);

  initial forever #25 sys_clk = ~sys_clk;

  task tally_and_finish;
    if (n_fail == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task cmp_rd(input logic [32:0] e, input logic [32:0] a);
    check_count++;
    if (e !== a)
    begin
      n_fail++;
      $display("CHECK FAILED %0t read exp %h got %h", $time, e, a);
    end
  endtask

  task cmp_hit(input logic [9:0] e, input logic [9:0] a);
    check_count++;
    if (e !== a)
    begin
      n_fail++;
      $display("CHECK FAILED %0t route exp %h got %h", $time, e, a);
    end
  endtask

  task apb(input logic w, input logic [19:0] idx, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    for (k = 0; k < 20; k++)
    begin
      @(posedge sys_clk);
      if (pready === 1'b1) break;
    end
    if (k == 20)
    begin
      n_fail++;
      tally_and_finish;
    end
    psel <= 0;
    penable <= 0;
  endtask

  task rd(input logic [19:0] idx, input logic [32:0] e);
    q_rd.push_back(e);
    apb(0, idx, 32'h0);
  endtask

  task fire(input logic [25:0] v, input evrt_code_t c);
    @(posedge sys_clk);
    src <= v;
    if (c inside {[1:10]}) q_hit.push_back(10'h1 << (c - 1));
    @(posedge sys_clk);
    src <= '0;
    repeat (3) @(posedge sys_clk);
  endtask

  // Fast paths are delayed one cycle so all destinations line up
  always @(posedge sys_clk)
  begin
    if (psel && penable && pready && !pwrite)
      cmp_rd(q_rd.size() > 0 ? q_rd.pop_front() : 'x, {pslverr, prdata});
    hit = {pwm_cutoff_detect, unit0_ch_trig[3:2], dac_event_detect, cap_timer1_chan_d_capture,
      cap_timer0_chan_d_capture, cnt_d, unit0_ch_trig[1:0], adc_d};
    adc_d <= adc_start_trig;
    cnt_d <= count_timer_src;
    if (hit !== 10'h0) cmp_hit(q_hit.size() > 0 ? q_hit.pop_front() : 10'h0, hit);
  end

  initial
  begin
    #500000;
    n_fail++;
    tally_and_finish;
  end

  initial
  begin
    int s;
    evrt_code_t c;
    logic [31:0] d;
    void'($urandom(32'h98A50F8D));
    repeat (16) @(posedge sys_clk);
    arst_n <= 1;
    for (s = 0; s < 26; s++) rd(EVRT_SEL_IDX_FIRST + s, 33'h0);
    rd(20'hF079A, {1'b1, 32'h0});
    for (int p = 0; p < 2; p++)
      for (s = 0; s < 26; s++)
      begin
        c = p ? evrt_code_t'($urandom_range(0, 10)) : evrt_code_t'(s % 11);
        d = $urandom;
        d[3:0] = c;
        apb(1, EVRT_SEL_IDX_FIRST + s, d);
        rd(EVRT_SEL_IDX_FIRST + s, {29'h0, c});
        fire(26'h1 << s, c);
      end
    apb(1, EVRT_SEL_IDX_FIRST, 32'h2);
    apb(1, EVRT_SEL_IDX_FIRST + 1, 32'h2);
    fire(26'h3, EVRT_CODE_CH0);
    // Every destination code 1-10 was exercised in the first pass
    rd(EVRT_STAT_IDX, {23'h0, 10'h3FF});
    apb(1, EVRT_STAT_IDX, 32'h0000_03FF);
    rd(EVRT_STAT_IDX, 33'h0);
    @(posedge sys_clk);
    arst_n <= 0;
    repeat (3) @(posedge sys_clk);
    arst_n <= 1;
    rd(EVRT_SEL_IDX_FIRST, 33'h0);
    fire(26'h1, EVRT_CODE_OFF);
    repeat (5) @(posedge sys_clk);
    if (q_rd.size() > 0 || q_hit.size() > 0) n_fail++;
    tally_and_finish;
  end
endmodule
